// ==== rtl/arcc_pkg.sv ====
// Shared constants of the audio route and clock control block
package arcc_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [6:0] ARCC_IDX_MISC2 = 7'h02;
    localparam logic [6:0] ARCC_IDX_ROUTE = 7'h03;
    localparam logic [6:0] ARCC_IDX_CLKSRC = 7'h04;
    localparam logic [6:0] ARCC_IDX_BUF_FIRST = 7'h20;
    localparam logic [6:0] ARCC_IDX_BUF_LAST = 7'h37;
    localparam int ARCC_BUF_DEPTH = 24;
    // Reset values
    localparam logic [6:0] ARCC_MISC2_RST = 7'h00;
    localparam logic [6:0] ARCC_ROUTE_RST = 7'h00;
    localparam logic [6:0] ARCC_CLKSRC_RST = 7'h00;
    // misc_control_two fields
    localparam int ARCC_F_MONO_CHANNEL = 0;
    localparam int ARCC_F_MONO_STATUS = 1;
    localparam int ARCC_F_MONO_TRANSMIT = 2;
    localparam int ARCC_F_MONO_RECEIVE = 3;
    localparam int ARCC_F_RECOV_RATIO = 4;
    localparam int ARCC_F_ERR_POLICY = 5;
    // data_route_control fields
    localparam int ARCC_F_CONV_IN = 0;
    localparam int ARCC_F_SEROUT_SRC = 1;
    localparam int ARCC_F_TX_SRC = 3;
    localparam int ARCC_F_BYPASS = 5;
    localparam int ARCC_F_TX_OFF = 6;
    // clock_source_select fields
    localparam int ARCC_F_RECOV_SRC = 0;
    localparam int ARCC_F_IN_TB = 2;
    localparam int ARCC_F_OUT_TB = 3;
    localparam int ARCC_F_MCLK_RATIO = 4;
    localparam int ARCC_F_RUN = 6;
    // Audio source codes
    typedef enum logic [1:0] {
        ARCC_SRC_CONVERTER = 2'b00,
        ARCC_SRC_SERIAL_IN = 2'b01,
        ARCC_SRC_RECEIVER = 2'b10,
        ARCC_SRC_RESERVED = 2'b11
    } arcc_src_t;
    // Recovered clock source codes
    typedef enum logic [1:0] {
        ARCC_RCK_WORD_SELECT = 2'b00,
        ARCC_RCK_BIPHASE = 2'b01,
        ARCC_RCK_EXT_RX_RESET = 2'b10,
        ARCC_RCK_EXT_RX_RUN = 2'b11
    } arcc_rck_t;
    // Error sample policy codes
    typedef enum logic [1:0] {
        ARCC_ERR_HOLD = 2'b00,
        ARCC_ERR_ZERO = 2'b01,
        ARCC_ERR_PASS = 2'b10,
        ARCC_ERR_RSVD = 2'b11
    } arcc_err_t;
    // Master clock ratios
    localparam logic [9:0] ARCC_RATIO_256 = 10'h100;
    localparam logic [9:0] ARCC_RATIO_384 = 10'h180;
    localparam logic [9:0] ARCC_RATIO_512 = 10'h200;
    localparam logic [9:0] ARCC_RECOV_MULT = 10'h100;
endpackage

// ==== rtl/arcc_source_mux.sv ====
// Audio source selector for one sink
`timescale 1ns/1ps
`default_nettype none
module arcc_source_mux
    import arcc_pkg::*;
#(
    parameter int W = 24
)(
    input wire logic [1:0] sel_i,
    input wire logic [W-1:0] converter_i,
    input wire logic converter_vld_i,
    input wire logic [W-1:0] serial_in_i,
    input wire logic serial_in_vld_i,
    input wire logic [W-1:0] receiver_i,
    input wire logic receiver_vld_i,
    output logic [W-1:0] data_o,
    output logic vld_o
);
    wire logic pick_conv = (sel_i == ARCC_SRC_CONVERTER);
    wire logic pick_ser = (sel_i == ARCC_SRC_SERIAL_IN);
    wire logic pick_rx = (sel_i == ARCC_SRC_RECEIVER);
    // Reserved code feeds silence
    assign data_o = pick_conv ? converter_i : pick_ser ? serial_in_i : pick_rx ? receiver_i : '0;
    assign vld_o = (pick_conv & converter_vld_i) | (pick_ser & serial_in_vld_i) | (pick_rx & receiver_vld_i);
endmodule
`default_nettype wire

// ==== rtl/arcc_status_pick.sv ====
// Channel status slot selection for the transmitter
`timescale 1ns/1ps
`default_nettype none
module arcc_status_pick (
    input wire logic mono_status_i,
    input wire logic mono_channel_i,
    input wire logic cs_left_i,
    input wire logic cs_right_i,
    output logic slot_a_o,
    output logic slot_b_o
);
    wire logic mono_bit = mono_channel_i ? cs_right_i : cs_left_i;
    assign slot_a_o = mono_status_i ? mono_bit : cs_left_i;
    assign slot_b_o = mono_status_i ? mono_bit : cs_right_i;
endmodule
`default_nettype wire

// ==== rtl/arcc_top.sv ====
// Audio routing and clock control registers with Wishbone access
//
// What this block does
// - Stereo status: A data in A, B in B
// - Mono status: same data, left or right
// - Transmitter off drives output constant low
// - Bypass feeds transmitter from positive receive input
// - Transmitter source: converter, serial, receiver
// - Serial output source: converter, serial, receiver
// - Converter input: serial port or receiver
// - Run low stops clocks, resets machines
// - Run low blocks status buffer access
// - Run resets low; software sets it
// - Master clock ratio 256, 384, 512
// - Output time base: master or recovered
// - Input time base: recovered or master
// - Recovered code 00: from word select
// - Recovered code 01: from biphase frames
// - Code 10: external clock, receiver reset
// - Code 11: external clock, receiver runs
`timescale 1ns/1ps
`default_nettype none
module arcc_top
    import arcc_pkg::*;
#(
    parameter int SAMPLE_W = 24
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Audio sources
    input wire logic [SAMPLE_W-1:0] converter_data_i,
    input wire logic converter_vld_i,
    input wire logic [SAMPLE_W-1:0] serial_in_data_i,
    input wire logic serial_in_vld_i,
    input wire logic [SAMPLE_W-1:0] receiver_data_i,
    input wire logic receiver_vld_i,
    input wire logic receiver_err_i,
    // Audio sinks
    output logic [SAMPLE_W-1:0] tx_data_o,
    output logic tx_vld_o,
    output logic [SAMPLE_W-1:0] serial_out_data_o,
    output logic serial_out_vld_o,
    output logic [SAMPLE_W-1:0] converter_in_data_o,
    output logic converter_in_vld_o,
    // Channel status bits
    input wire logic cs_left_i,
    input wire logic cs_right_i,
    output logic cs_slot_a_o,
    output logic cs_slot_b_o,
    // Transmitter line
    input wire logic tx_line_i,
    input wire logic receive_positive_input_i,
    output logic tx_drive_o,
    // Clocking controls
    input wire logic serial_in_master_i,
    output logic run_o,
    output logic core_reset_o,
    output logic [9:0] master_clock_ratio_o,
    output logic output_timebase_sel_o,
    output logic input_timebase_sel_o,
    output logic [9:0] recovered_clock_ratio_o,
    output logic pll_bypass_o,
    output logic pll_ref_biphase_o,
    output logic receiver_sync_reset_o,
    output logic recovered_source_invalid_o,
    output logic mono_receive_sel_o,
    output logic mono_transmit_sel_o
);
    if (SAMPLE_W < 1 || SAMPLE_W > 32)
    begin
        $error("SAMPLE_W out of range");
    end

    // Control registers, bit seven not stored
    logic [6:0] misc_control_two_r, data_route_control_r, clock_source_select_r;
    logic [7:0] buf_mem_r [ARCC_BUF_DEPTH];
    logic [31:0] dat_r;
    logic [SAMPLE_W-1:0] held_r, tx_data_r, sout_data_r, conv_data_r;
    logic [9:0] mratio_r, rratio_r;
    logic ack_r, rxp_meta_r, rxp_sync_r, tx_vld_r, sout_vld_r, conv_vld_r, cs_a_r, cs_b_r, tx_drive_r, run_r;
    logic core_reset_r, out_tb_r, in_tb_r, pll_bypass_r, pll_ref_r, rx_reset_r, rsrc_bad_r, mono_rx_r, mono_tx_r;

    function automatic logic [9:0] ratio_of(input logic [1:0] code);
        case (code)
            2'b00: ratio_of = ARCC_RATIO_256;
            2'b01: ratio_of = ARCC_RATIO_384;
            2'b10: ratio_of = ARCC_RATIO_512;
            default: ratio_of = ARCC_RATIO_256;
        endcase
    endfunction

    // Bus decode
    wire logic [6:0] idx = wb_adr_i[8:2];
    wire logic req = wb_cyc_i & wb_stb_i & ~ack_r;
    wire logic wr_lane0 = req & wb_we_i & wb_sel_i[0];
    wire logic hit_misc2 = (idx == ARCC_IDX_MISC2);
    wire logic hit_route = (idx == ARCC_IDX_ROUTE);
    wire logic hit_clksrc = (idx == ARCC_IDX_CLKSRC);
    wire logic hit_buf = (idx >= ARCC_IDX_BUF_FIRST) && (idx <= ARCC_IDX_BUF_LAST);
    wire logic [4:0] buf_idx = 5'(idx - ARCC_IDX_BUF_FIRST);
    wire logic run_bit = clock_source_select_r[ARCC_F_RUN];
    wire logic buf_open = hit_buf & run_bit;
    wire logic buf_wr = wr_lane0 & buf_open;

    // Field views
    wire logic mono_channel = misc_control_two_r[ARCC_F_MONO_CHANNEL];
    wire logic mono_status = misc_control_two_r[ARCC_F_MONO_STATUS];
    wire logic [1:0] err_policy = misc_control_two_r[ARCC_F_ERR_POLICY +: 2];
    wire logic recov_ratio = misc_control_two_r[ARCC_F_RECOV_RATIO];
    wire logic conv_in_sel = data_route_control_r[ARCC_F_CONV_IN];
    wire logic [1:0] sout_sel = data_route_control_r[ARCC_F_SEROUT_SRC +: 2];
    wire logic [1:0] tx_sel = data_route_control_r[ARCC_F_TX_SRC +: 2];
    wire logic bypass = data_route_control_r[ARCC_F_BYPASS];
    wire logic tx_off = data_route_control_r[ARCC_F_TX_OFF];
    wire logic [1:0] rck_src = clock_source_select_r[ARCC_F_RECOV_SRC +: 2];
    wire logic [1:0] mclk_code = clock_source_select_r[ARCC_F_MCLK_RATIO +: 2];

    // Read data, bit seven zero for control registers
    wire logic [7:0] buf_rd = buf_open ? buf_mem_r[buf_idx] : 8'h00;
    wire logic [7:0] rd_byte = hit_misc2 ? {1'b0, misc_control_two_r} :
                               hit_route ? {1'b0, data_route_control_r} :
                               hit_clksrc ? {1'b0, clock_source_select_r} : buf_rd;

    // Receiver sample after error policy
    logic [SAMPLE_W-1:0] rx_clean;
    always_comb
    begin
        rx_clean = receiver_data_i;
        if (receiver_err_i)
        begin
            case (err_policy)
                ARCC_ERR_HOLD: rx_clean = held_r;
                ARCC_ERR_ZERO: rx_clean = '0;
                ARCC_ERR_PASS: rx_clean = receiver_data_i;
                default: rx_clean = held_r;
            endcase
        end
    end

    // Source selection
    wire logic [SAMPLE_W-1:0] tx_mux, sout_mux;
    wire logic tx_mux_vld, sout_mux_vld;
    wire logic [SAMPLE_W-1:0] conv_mux = conv_in_sel ? rx_clean : serial_in_data_i;
    wire logic conv_mux_vld = conv_in_sel ? receiver_vld_i : serial_in_vld_i;

    arcc_source_mux #(
        .W(SAMPLE_W)
    ) u_tx_mux (
        .sel_i(tx_sel),
        .converter_i(converter_data_i),
        .converter_vld_i(converter_vld_i),
        .serial_in_i(serial_in_data_i),
        .serial_in_vld_i(serial_in_vld_i),
        .receiver_i(rx_clean),
        .receiver_vld_i(receiver_vld_i),
        .data_o(tx_mux),
        .vld_o(tx_mux_vld)
    );

    arcc_source_mux #(
        .W(SAMPLE_W)
    ) u_sout_mux (
        .sel_i(sout_sel),
        .converter_i(converter_data_i),
        .converter_vld_i(converter_vld_i),
        .serial_in_i(serial_in_data_i),
        .serial_in_vld_i(serial_in_vld_i),
        .receiver_i(rx_clean),
        .receiver_vld_i(receiver_vld_i),
        .data_o(sout_mux),
        .vld_o(sout_mux_vld)
    );

    wire logic cs_a_nxt, cs_b_nxt;

    arcc_status_pick u_status (
        .mono_status_i(mono_status),
        .mono_channel_i(mono_channel),
        .cs_left_i(cs_left_i),
        .cs_right_i(cs_right_i),
        .slot_a_o(cs_a_nxt),
        .slot_b_o(cs_b_nxt)
    );

    // Transmitter drive
    wire logic drive_src = bypass ? rxp_sync_r : tx_line_i;
    wire logic tx_drive_nxt = tx_off ? 1'b0 : drive_src;

    // Recovered clock decode
    wire logic ext_clock = (rck_src == ARCC_RCK_EXT_RX_RESET) || (rck_src == ARCC_RCK_EXT_RX_RUN);
    wire logic rx_hold = (rck_src == ARCC_RCK_EXT_RX_RESET) || ~run_bit;
    wire logic ref_biphase = (rck_src == ARCC_RCK_BIPHASE);
    wire logic ws_invalid = (rck_src == ARCC_RCK_WORD_SELECT) & serial_in_master_i;
    wire logic [9:0] rratio_nxt = recov_ratio ? {1'b0, ARCC_RECOV_MULT[9:1]} : ARCC_RECOV_MULT;

    // Bus slave and registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            misc_control_two_r <= ARCC_MISC2_RST;
            data_route_control_r <= ARCC_ROUTE_RST;
            clock_source_select_r <= ARCC_CLKSRC_RST;
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end
        else if (ce_i)
        begin
            ack_r <= req;
            dat_r <= req ? {24'h0, rd_byte} : 32'h0;
            if (wr_lane0 & hit_misc2)
            begin
                misc_control_two_r <= wb_dat_i[6:0];
            end
            if (wr_lane0 & hit_route)
            begin
                data_route_control_r <= wb_dat_i[6:0];
            end
            if (wr_lane0 & hit_clksrc)
            begin
                clock_source_select_r <= wb_dat_i[6:0];
            end
        end
    end

    // Status buffer storage
    always_ff @(posedge clk_i)
    begin
        if (ce_i && buf_wr)
        begin
            buf_mem_r[buf_idx] <= wb_dat_i[7:0];
        end
    end

    // Positive receive input synchroniser
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rxp_meta_r <= 1'b0;
            rxp_sync_r <= 1'b0;
        end
        else if (ce_i)
        begin
            rxp_meta_r <= receive_positive_input_i;
            rxp_sync_r <= rxp_meta_r;
        end
    end

    // Audio path, cleared while stopped
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (ce_i && ~run_bit))
        begin
            held_r <= '0;
            tx_data_r <= '0;
            tx_vld_r <= 1'b0;
            sout_data_r <= '0;
            sout_vld_r <= 1'b0;
            conv_data_r <= '0;
            conv_vld_r <= 1'b0;
            cs_a_r <= 1'b0;
            cs_b_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (receiver_vld_i & ~receiver_err_i)
            begin
                held_r <= receiver_data_i;
            end
            tx_data_r <= tx_mux;
            tx_vld_r <= tx_mux_vld;
            sout_data_r <= sout_mux;
            sout_vld_r <= sout_mux_vld;
            conv_data_r <= conv_mux;
            conv_vld_r <= conv_mux_vld;
            cs_a_r <= cs_a_nxt;
            cs_b_r <= cs_b_nxt;
        end
    end

    // Clocking control outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_drive_r <= 1'b0;
            run_r <= 1'b0;
            core_reset_r <= 1'b1;
            mratio_r <= ARCC_RATIO_256;
            out_tb_r <= 1'b0;
            in_tb_r <= 1'b0;
            rratio_r <= ARCC_RECOV_MULT;
            pll_bypass_r <= 1'b0;
            pll_ref_r <= 1'b0;
            rx_reset_r <= 1'b1;
            rsrc_bad_r <= 1'b0;
            mono_rx_r <= 1'b0;
            mono_tx_r <= 1'b0;
        end
        else if (ce_i)
        begin
            tx_drive_r <= tx_drive_nxt;
            run_r <= run_bit;
            core_reset_r <= ~run_bit;
            mratio_r <= ratio_of(mclk_code);
            out_tb_r <= clock_source_select_r[ARCC_F_OUT_TB];
            in_tb_r <= clock_source_select_r[ARCC_F_IN_TB];
            rratio_r <= rratio_nxt;
            pll_bypass_r <= ext_clock;
            pll_ref_r <= ref_biphase;
            rx_reset_r <= rx_hold;
            rsrc_bad_r <= ws_invalid;
            mono_rx_r <= misc_control_two_r[ARCC_F_MONO_RECEIVE];
            mono_tx_r <= misc_control_two_r[ARCC_F_MONO_TRANSMIT];
        end
    end

    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign tx_data_o = tx_data_r;
    assign tx_vld_o = tx_vld_r;
    assign serial_out_data_o = sout_data_r;
    assign serial_out_vld_o = sout_vld_r;
    assign converter_in_data_o = conv_data_r;
    assign converter_in_vld_o = conv_vld_r;
    assign cs_slot_a_o = cs_a_r;
    assign cs_slot_b_o = cs_b_r;
    assign tx_drive_o = tx_drive_r;
    assign run_o = run_r;
    assign core_reset_o = core_reset_r;
    assign master_clock_ratio_o = mratio_r;
    assign output_timebase_sel_o = out_tb_r;
    assign input_timebase_sel_o = in_tb_r;
    assign recovered_clock_ratio_o = rratio_r;
    assign pll_bypass_o = pll_bypass_r;
    assign pll_ref_biphase_o = pll_ref_r;
    assign receiver_sync_reset_o = rx_reset_r;
    assign recovered_source_invalid_o = rsrc_bad_r;
    assign mono_receive_sel_o = mono_rx_r;
    assign mono_transmit_sel_o = mono_tx_r;
endmodule
`default_nettype wire

// ==== tb/arcc_top_sva.sv ====
// Checker of register access, routing and clock selection
`timescale 1ns/1ps
`default_nettype none
module arcc_top_sva #(
    parameter int SAMPLE_W = 24
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [SAMPLE_W-1:0] converter_data_i,
    input wire logic converter_vld_i,
    input wire logic [SAMPLE_W-1:0] serial_in_data_i,
    input wire logic serial_in_vld_i,
    input wire logic [SAMPLE_W-1:0] tx_data_o,
    input wire logic tx_vld_o,
    input wire logic [SAMPLE_W-1:0] serial_out_data_o,
    input wire logic serial_out_vld_o,
    input wire logic cs_left_i,
    input wire logic cs_right_i,
    input wire logic cs_slot_a_o,
    input wire logic cs_slot_b_o,
    input wire logic tx_drive_o,
    input wire logic core_reset_o,
    input wire logic [9:0] master_clock_ratio_o,
    input wire logic pll_bypass_o,
    input wire logic receiver_sync_reset_o
);
    logic [6:0] sh_misc_r, sh_route_r, sh_clk_r;
    wire take_w = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    wire ctrl_w = wb_adr_i[8:2] inside {7'h02, 7'h03, 7'h04};
    wire mono_w = sh_misc_r[0] ? cs_right_i : cs_left_i;
    wire slot_a_w = sh_misc_r[1] ? mono_w : cs_left_i;
    wire slot_b_w = sh_misc_r[1] ? mono_w : cs_right_i;
    wire [SAMPLE_W:0] conv_w = {converter_vld_i, converter_data_i};
    wire [SAMPLE_W:0] ser_w = {serial_in_vld_i, serial_in_data_i};
    wire [SAMPLE_W:0] tx_exp_w = (sh_route_r[4:3] == 2'b00) ? conv_w : (sh_route_r[4:3] == 2'b01) ? ser_w : '0;
    wire [SAMPLE_W:0] so_exp_w = (sh_route_r[2:1] == 2'b00) ? conv_w : (sh_route_r[2:1] == 2'b01) ? ser_w : '0;
    wire [9:0] ratio_w = (sh_clk_r[5:4] == 2'b01) ? 10'h180 : (sh_clk_r[5:4] == 2'b10) ? 10'h200 : 10'h100;

    // Shadow of the control registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sh_misc_r <= 7'h00;
            sh_route_r <= 7'h00;
            sh_clk_r <= 7'h00;
        end
        else if (take_w)
        begin
            if (wb_adr_i[8:2] == 7'h02)
                sh_misc_r <= wb_dat_i[6:0];
            if (wb_adr_i[8:2] == 7'h03)
                sh_route_r <= wb_dat_i[6:0];
            if (wb_adr_i[8:2] == 7'h04)
                sh_clk_r <= wb_dat_i[6:0];
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_next_cycle: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_single_pulse: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ctrl_bit7_zero: assert property (wb_ack_o && !wb_we_i && ctrl_w |-> wb_dat_o[31:7] == 25'h0)
        else $error("bit 7 set");
    a_status_slots: assert property (ce_i && sh_clk_r[6] |=> {cs_slot_a_o, cs_slot_b_o} == $past({slot_a_w, slot_b_w}))
        else $error("status slot wrong");
    a_tx_off_low: assert property (ce_i && sh_route_r[6] |=> !tx_drive_o)
        else $error("drive not low");
    a_tx_source: assert property (ce_i && sh_clk_r[6] && sh_route_r[4:3] != 2'b10 |=> {tx_vld_o, tx_data_o} == $past(tx_exp_w))
        else $error("tx source wrong");
    a_serout_source: assert property (ce_i && sh_clk_r[6] && sh_route_r[2:1] != 2'b10 |=> {serial_out_vld_o, serial_out_data_o} == $past(so_exp_w))
        else $error("serial source wrong");
    a_run_stopped: assert property (ce_i && !sh_clk_r[6] |=> core_reset_o && !tx_vld_o && !serial_out_vld_o && !cs_slot_a_o)
        else $error("activity while stopped");
    a_ratio_code: assert property (ce_i |=> master_clock_ratio_o == $past(ratio_w))
        else $error("ratio wrong");
    a_recov_modes: assert property (ce_i |=> pll_bypass_o == $past(sh_clk_r[1]) && receiver_sync_reset_o == $past(sh_clk_r[1:0] == 2'b10 || !sh_clk_r[6]))
        else $error("recovered mode wrong");
endmodule
`default_nettype wire

// ==== tb/arcc_top_tb_top.sv ====
// Self-checking bench of the audio route and clock control block
`timescale 1ns/1ps
`default_nettype none
module arcc_top_tb_top
    import arcc_pkg::*;
;
    localparam int SW = 24;
    localparam logic [3:0][9:0] RATIO_EXP = {10'h100, 10'h200, 10'h180, 10'h100};
    localparam logic [3:0][5:0] RCK_EXP = {6'h38, 6'h2A, 6'h14, 6'h01};
    localparam logic [3:0][31:0] SRC_EXP = {32'h0, 32'h1333333, 32'h1222222, 32'h1111111};
    localparam logic [2:0][9:0] CS_EXP = {10'h3_0, 10'h2_3, 10'h0_2};
    logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [8:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [SW-1:0] converter_data_i, serial_in_data_i, receiver_data_i, tx_data_o, serial_out_data_o;
    logic [SW-1:0] converter_in_data_o;
    logic converter_vld_i, serial_in_vld_i, receiver_vld_i, receiver_err_i, tx_vld_o, serial_out_vld_o;
    logic converter_in_vld_o, cs_left_i, cs_right_i, cs_slot_a_o, cs_slot_b_o, tx_line_i, tx_drive_o;
    logic receive_positive_input_i, serial_in_master_i, run_o, core_reset_o, output_timebase_sel_o;
    logic input_timebase_sel_o, pll_bypass_o, pll_ref_biphase_o, receiver_sync_reset_o;
    logic recovered_source_invalid_o, mono_receive_sel_o, mono_transmit_sel_o;
    logic [9:0] master_clock_ratio_o, recovered_clock_ratio_o;
    int n_errors, check_count;

    arcc_top #(.SAMPLE_W(SW)) dut (
        .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .converter_data_i, .converter_vld_i, .serial_in_data_i, .serial_in_vld_i, .receiver_data_i,
        .receiver_vld_i, .receiver_err_i, .tx_data_o, .tx_vld_o, .serial_out_data_o, .serial_out_vld_o,
        .converter_in_data_o, .converter_in_vld_o, .cs_left_i, .cs_right_i, .cs_slot_a_o, .cs_slot_b_o,
        .tx_line_i, .receive_positive_input_i, .tx_drive_o, .serial_in_master_i, .run_o, .core_reset_o,
        .master_clock_ratio_o, .output_timebase_sel_o, .input_timebase_sel_o, .recovered_clock_ratio_o,
        .pll_bypass_o, .pll_ref_biphase_o, .receiver_sync_reset_o, .recovered_source_invalid_o,
        .mono_receive_sel_o, .mono_transmit_sel_o
    );

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle
    task automatic wb_acc(input logic we, input logic [6:0] idx, input logic [7:0] d, input logic s0);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= {4{s0}};
        wb_dat_i <= {24'h0, d};
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && ++n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50)
            n_errors++;
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        wb_acc(1'b1, idx, d, 1'b1);
    endtask

    task automatic rdchk(input logic [6:0] idx, input logic [7:0] exp);
        wb_acc(1'b0, idx, 8'h00, 1'b1);
        check(rd, {24'h0, exp});
    endtask

    task automatic settle;
        repeat (4) @(posedge clk_i);
        #1;
    endtask

    task automatic rx(input logic [23:0] d, input logic err);
        @(posedge clk_i);
        receiver_data_i <= d;
        receiver_err_i <= err;
        settle();
    endtask

    task automatic errchk(input logic [1:0] pol, input logic [23:0] d, input logic err, input logic [31:0] exp);
        wr(ARCC_IDX_MISC2, {1'b0, pol, 5'h00});
        rx(d, err);
        check({7'h0, tx_vld_o, tx_data_o}, exp);
    endtask

    task automatic drv(input logic [7:0] route, input logic line, input logic pin, input logic exp);
        wr(ARCC_IDX_ROUTE, route);
        tx_line_i <= line;
        receive_positive_input_i <= pin;
        settle();
        check(32'(tx_drive_o), 32'(exp));
    endtask

    task automatic final_report;
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        final_report();
    end

    initial
    begin
        {rst_i, ce_i, converter_vld_i, serial_in_vld_i, receiver_vld_i} = 5'h1F;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {receiver_err_i, cs_right_i, tx_line_i, receive_positive_input_i, serial_in_master_i} = '0;
        cs_left_i = 1'b1;
        converter_data_i = 24'h111111;
        serial_in_data_i = 24'h222222;
        receiver_data_i = 24'h333333;
        n_errors = 0;
        check_count = 0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        check({31'h0, run_o}, 32'h0);
        check({22'h0, master_clock_ratio_o}, 32'h100);
        rdchk(ARCC_IDX_CLKSRC, 8'h00);
        for (int i = 2; i < 5; i++)
        begin
            wr(i[6:0], 8'hFF);
            rdchk(i[6:0], 8'h7F);
            wr(i[6:0], 8'h00);
        end
        wb_acc(1'b1, ARCC_IDX_ROUTE, 8'h55, 1'b0);
        rdchk(ARCC_IDX_ROUTE, 8'h00);
        wr(7'h10, 8'hAA);
        rdchk(7'h10, 8'h00);
        wr(ARCC_IDX_BUF_FIRST, 8'h5A);
        rdchk(ARCC_IDX_BUF_FIRST, 8'h00);
        wr(ARCC_IDX_CLKSRC, 8'h40);
        wr(ARCC_IDX_BUF_LAST, 8'hA5);
        rdchk(ARCC_IDX_BUF_LAST, 8'hA5);
        for (int c = 0; c < 4; c++)
        begin
            wr(ARCC_IDX_ROUTE, {3'b000, c[1:0], c[1:0], c[0]});
            settle();
            check({7'h0, tx_vld_o, tx_data_o}, SRC_EXP[c]);
            check({7'h0, serial_out_vld_o, serial_out_data_o}, SRC_EXP[c]);
            check({7'h0, converter_in_vld_o, converter_in_data_o}, SRC_EXP[c[0] + 1]);
        end
        wr(ARCC_IDX_ROUTE, 8'h10);
        errchk(2'b00, 24'h333333, 1'b0, 32'h1333333);
        errchk(2'b00, 24'h555555, 1'b1, 32'h1333333);
        errchk(2'b01, 24'h555555, 1'b1, 32'h1000000);
        errchk(2'b10, 24'h555555, 1'b1, 32'h1555555);
        for (int m = 0; m < 3; m++)
        begin
            wr(ARCC_IDX_MISC2, {6'h00, CS_EXP[m][5:4]});
            settle();
            check({30'h0, cs_slot_a_o, cs_slot_b_o}, {30'h0, CS_EXP[m][1:0]});
        end
        drv(8'h40, 1'b1, 1'b0, 1'b0);
        drv(8'h00, 1'b1, 1'b0, 1'b1);
        drv(8'h20, 1'b0, 1'b1, 1'b1);
        drv(8'h20, 1'b1, 1'b0, 1'b0);
        for (int c = 0; c < 4; c++)
        begin
            wr(ARCC_IDX_CLKSRC, 8'h40);
            wr(ARCC_IDX_CLKSRC, 8'h00);
            wr(ARCC_IDX_CLKSRC, {2'b00, c[1:0], 4'h0});
            wr(ARCC_IDX_CLKSRC, {2'b01, c[1:0], 4'h0});
            settle();
            check({22'h0, master_clock_ratio_o}, {22'h0, RATIO_EXP[c]});
        end
        wr(ARCC_IDX_MISC2, 8'h9C);
        serial_in_master_i <= 1'b1;
        for (int r = 0; r < 4; r++)
        begin
            wr(ARCC_IDX_CLKSRC, {4'h4, r[1:0], r[1:0]});
            settle();
            check(32'({run_o, recovered_clock_ratio_o, mono_receive_sel_o, mono_transmit_sel_o,
                output_timebase_sel_o, input_timebase_sel_o, pll_bypass_o, pll_ref_biphase_o,
                receiver_sync_reset_o, recovered_source_invalid_o}), {13'h0, 13'h1203, RCK_EXP[r]});
        end
        wr(ARCC_IDX_CLKSRC, 8'h00);
        settle();
        check({7'h0, tx_vld_o, tx_data_o}, 32'h0);
        check({31'h0, core_reset_o}, 32'h1);
        rdchk(ARCC_IDX_BUF_LAST, 8'h00);
        final_report();
    end
endmodule

bind arcc_top arcc_top_sva #(.SAMPLE_W(SAMPLE_W)) u_sva (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .converter_data_i, .converter_vld_i, .serial_in_data_i, .serial_in_vld_i, .tx_data_o,
    .tx_vld_o, .serial_out_data_o, .serial_out_vld_o, .cs_left_i, .cs_right_i, .cs_slot_a_o, .cs_slot_b_o,
    .tx_drive_o, .core_reset_o, .master_clock_ratio_o, .pll_bypass_o, .receiver_sync_reset_o
);
`default_nettype wire
